// *** rtl/wdt_regs.vh ***
// Purpose: Constants for the system watchdog timer
// Assumes: 25 MHz bus clock, 32-bit AXI4-Lite register access
// Notes: Register offsets are byte addresses
//
// Notes on behaviour
// - Every reset leaves the watchdog enable set, so it runs by default.
// - With the enable cleared the watchdog stops and never resets the system.
// - Any write to the reset cause address restarts the counter from zero.
// - That service write leaves the reset cause contents unchanged.
// - Clock select 0 picks the 32 kHz reference, 1 picks the bus clock.
// - Time-out select: reference 2^10 or 2^13, bus clock 2^13 or 2^18 cycles.
// - After reset: reference clock and long time-out.
// - Both option registers take only their first write after reset.
// - The first write to either option register restarts the counter.
// - In background debug mode the counter holds its value.
// - Bus clock selected: counter freezes in stop mode, then resumes.
// - Reference selected: counter clears on stop entry, restarts from zero.
// - Reaching the selected overflow count while enabled requests system reset.
// - Reference time-outs assume a nominal 31.25 us tick period, within clock tolerance.
// - A watchdog reset sets the watchdog bit of the reset cause register.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDT_OPT1_ADDR 8'h00
`define WDT_OPT2_ADDR 8'h04
`define WDT_CAUSE_ADDR 8'h08
`define WDT_STAT_ADDR 8'h0c
`define WDT_MASK_ADDR 8'h10
`define WDT_COUNT_ADDR 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define WDT_OPT1_ENABLE_BIT 0
`define WDT_OPT1_TIMEOUT_BIT 1
`define WDT_OPT2_CLKSEL_BIT 0
`define WDT_CAUSE_WDT_BIT 0
`define WDT_CAUSE_POR_BIT 1
`define WDT_ENABLE_RST 1'b1
`define WDT_TIMEOUT_RST 1'b1
`define WDT_CLKSEL_RST 1'b0
`define WDT_EV_SERVICE_BIT 0
`define WDT_EV_TIMEOUT_BIT 1
`define WDT_EV_LOCKED_BIT 2
`define WDT_EV_WIDTH 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_CLK_HZ 25000000
`define WDT_REF_HZ 32000
// Reference divider, bus clock over reference rate, sized for the divider port
`define WDT_REF_DIV 10'd781
`define WDT_CNT_WIDTH 19
`define WDT_LIM_REF_SHORT 19'h00400
`define WDT_LIM_REF_LONG 19'h02000
`define WDT_LIM_BUS_SHORT 19'h02000
`define WDT_LIM_BUS_LONG 19'h40000

`endif

// *** rtl/wdt_tick_div.v ***
// Purpose: One-cycle enable pulse at the reference clock rate
// Assumes: Single clock domain
// Notes: Clear restarts the phase
`timescale 1ns/10ps
module wdt_tick_div #(
	parameter [9:0] DIV = 10'd781
) (
	input wire aclk,
	input wire aresetn,
	input wire clear,
	output reg tick
);

// ----------------------------------------
// Divider
// ----------------------------------------
reg [9:0] div_r;

always @(posedge aclk) begin
	if (!aresetn || clear) begin
		div_r <= 10'h000;
		tick <= 1'b0;
	end else if (div_r == DIV - 10'd1) begin
		div_r <= 10'h000;
		tick <= 1'b1;
	end else begin
		div_r <= div_r + 10'd1;
		tick <= 1'b0;
	end
end

endmodule

// *** rtl/wdt_counter.v ***
// Purpose: Watchdog up-counter with selectable overflow
// Assumes: Increment enable from the top
// Notes: Overflow is a single-cycle pulse
`timescale 1ns/10ps
`include "wdt_regs.vh"
module wdt_counter (
	input wire aclk,
	input wire aresetn,
	input wire clear,
	input wire inc,
	input wire clksel,
	input wire timeout_sel,
	output reg [`WDT_CNT_WIDTH-1:0] count,
	output reg overflow
);

// ----------------------------------------
// Limit select
// ----------------------------------------
reg [`WDT_CNT_WIDTH-1:0] limit;

always @* begin
	case ({clksel, timeout_sel})
	2'b00: limit = `WDT_LIM_REF_SHORT;
	2'b01: limit = `WDT_LIM_REF_LONG;
	2'b10: limit = `WDT_LIM_BUS_SHORT;
	default: limit = `WDT_LIM_BUS_LONG;
	endcase
end

// ----------------------------------------
// Count
// ----------------------------------------
always @(posedge aclk) begin
	if (!aresetn || clear) begin
		count <= {`WDT_CNT_WIDTH{1'b0}};
		overflow <= 1'b0;
	end else if (inc && count == limit - 1'b1) begin
		count <= {`WDT_CNT_WIDTH{1'b0}};
		overflow <= 1'b1;
	end else begin
		if (inc)
			count <= count + 1'b1;
		overflow <= 1'b0;
	end
end

endmodule

// *** rtl/wdt_top.v ***
// Purpose: System watchdog timer with AXI4-Lite registers
// Assumes: Stop and debug inputs come from logic on aclk
// Notes: Watchdog reset request is a one-cycle pulse
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "wdt_regs.vh"
module wdt_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire stop_mode,
	input wire debug_mode,
	input wire por_event,
	output reg wdt_reset_req,
	output reg irq
);

// ----------------------------------------
// Write channel capture
// ----------------------------------------
reg aw_held_r;
reg w_held_r;
reg [7:0] awaddr_r;
reg [31:0] wdata_r;
wire wr_fire;

assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held_r <= 1'b0;
		w_held_r <= 1'b0;
		awaddr_r <= 8'h00;
		wdata_r <= 32'h00000000;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
	end else begin
		s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
		s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
		if (aw_held_r || (s_axi_awvalid && s_axi_awready))
			s_axi_awready <= 1'b0;
		if (w_held_r || (s_axi_wvalid && s_axi_wready))
			s_axi_wready <= 1'b0;
	end
end

// ----------------------------------------
// Write response
// ----------------------------------------
wire wr_known;

assign wr_known = awaddr_r == `WDT_OPT1_ADDR || awaddr_r == `WDT_OPT2_ADDR ||
	awaddr_r == `WDT_CAUSE_ADDR || awaddr_r == `WDT_STAT_ADDR ||
	awaddr_r == `WDT_MASK_ADDR || awaddr_r == `WDT_COUNT_ADDR;

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'b00;
	end else if (wr_fire) begin
		s_axi_bvalid <= 1'b1;
		s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
	end else if (s_axi_bready) begin
		s_axi_bvalid <= 1'b0;
	end
end

// ----------------------------------------
// Option registers, write once; interrupt mask, writable any time
// ----------------------------------------
reg enable_r;
reg timeout_sel_r;
reg clksel_r;
reg opt1_locked_r;
reg opt2_locked_r;
reg [3:0] mask_r;
wire wr_opt1;
wire wr_opt2;
wire wr_service;
wire wr_mask;

assign wr_opt1 = wr_fire && awaddr_r == `WDT_OPT1_ADDR;
assign wr_opt2 = wr_fire && awaddr_r == `WDT_OPT2_ADDR;
assign wr_service = wr_fire && awaddr_r == `WDT_CAUSE_ADDR;
assign wr_mask = wr_fire && awaddr_r == `WDT_MASK_ADDR;

always @(posedge aclk) begin
	if (!aresetn) begin
		enable_r <= `WDT_ENABLE_RST;
		timeout_sel_r <= `WDT_TIMEOUT_RST;
		clksel_r <= `WDT_CLKSEL_RST;
		opt1_locked_r <= 1'b0;
		opt2_locked_r <= 1'b0;
		mask_r <= 4'h0;
	end else begin
		if (wr_opt1 && !opt1_locked_r) begin
			enable_r <= wdata_r[`WDT_OPT1_ENABLE_BIT];
			timeout_sel_r <= wdata_r[`WDT_OPT1_TIMEOUT_BIT];
			opt1_locked_r <= 1'b1;
		end
		if (wr_opt2 && !opt2_locked_r) begin
			clksel_r <= wdata_r[`WDT_OPT2_CLKSEL_BIT];
			opt2_locked_r <= 1'b1;
		end
		if (wr_mask)
			mask_r <= wdata_r[3:0];
	end
end

// ----------------------------------------
// Counter control
// ----------------------------------------
reg stop_d_r;
wire stop_entry;
wire ref_tick;
wire cnt_clear;
wire cnt_inc;
wire [`WDT_CNT_WIDTH-1:0] count;
wire overflow;

assign stop_entry = stop_mode && !stop_d_r;
assign cnt_clear = wr_service || (wr_opt1 && !opt1_locked_r) ||
	(wr_opt2 && !opt2_locked_r) || !enable_r ||
	(stop_entry && !clksel_r);
assign cnt_inc = enable_r && !debug_mode && !stop_mode &&
	(clksel_r ? 1'b1 : ref_tick);

always @(posedge aclk) begin
	if (!aresetn)
		stop_d_r <= 1'b0;
	else
		stop_d_r <= stop_mode;
end

wdt_tick_div #(
	.DIV(`WDT_REF_DIV)
) u_tick (
	.aclk(aclk),
	.aresetn(aresetn),
	.clear(stop_entry && !clksel_r),
	.tick(ref_tick)
);

wdt_counter u_cnt (
	.aclk(aclk),
	.aresetn(aresetn),
	.clear(cnt_clear),
	.inc(cnt_inc),
	.clksel(clksel_r),
	.timeout_sel(timeout_sel_r),
	.count(count),
	.overflow(overflow)
);

// ----------------------------------------
// Reset request and reset cause
// ----------------------------------------
reg cause_wdt_r;
reg cause_por_r;

always @(posedge aclk) begin
	if (!aresetn)
		wdt_reset_req <= 1'b0;
	else
		wdt_reset_req <= overflow && enable_r;
end

// Cause bits survive the watchdog reset it caused
always @(posedge aclk) begin
	if (por_event) begin
		cause_wdt_r <= 1'b0;
		cause_por_r <= 1'b1;
	end else if (wdt_reset_req) begin
		cause_wdt_r <= 1'b1;
		cause_por_r <= 1'b0;
	end
end

// ----------------------------------------
// Event status and interrupt
// ----------------------------------------
reg [`WDT_EV_WIDTH-1:0] stat_r;
reg [`WDT_EV_WIDTH-1:0] ev;
wire rd_stat;

always @* begin
	ev = {`WDT_EV_WIDTH{1'b0}};
	ev[`WDT_EV_SERVICE_BIT] = wr_service;
	ev[`WDT_EV_TIMEOUT_BIT] = overflow && enable_r;
	ev[`WDT_EV_LOCKED_BIT] = (wr_opt1 && opt1_locked_r) || (wr_opt2 && opt2_locked_r);
end

always @(posedge aclk) begin
	if (!aresetn) begin
		stat_r <= {`WDT_EV_WIDTH{1'b0}};
		irq <= 1'b0;
	end else begin
		if (rd_stat)
			stat_r <= ev;
		else
			stat_r <= stat_r | ev;
		irq <= |(stat_r & mask_r[`WDT_EV_WIDTH-1:0]);
	end
end

// ----------------------------------------
// Read channel
// ----------------------------------------
reg [31:0] rd_mux;
reg rd_ok;

assign rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == `WDT_STAT_ADDR;

always @* begin
	rd_mux = 32'h00000000;
	rd_ok = 1'b1;
	case (s_axi_araddr)
	`WDT_OPT1_ADDR: begin
		rd_mux[`WDT_OPT1_ENABLE_BIT] = enable_r;
		rd_mux[`WDT_OPT1_TIMEOUT_BIT] = timeout_sel_r;
	end
	`WDT_OPT2_ADDR: rd_mux[`WDT_OPT2_CLKSEL_BIT] = clksel_r;
	`WDT_CAUSE_ADDR: begin
		rd_mux[`WDT_CAUSE_WDT_BIT] = cause_wdt_r;
		rd_mux[`WDT_CAUSE_POR_BIT] = cause_por_r;
	end
	`WDT_STAT_ADDR: rd_mux[`WDT_EV_WIDTH-1:0] = stat_r;
	`WDT_MASK_ADDR: rd_mux[3:0] = mask_r;
	`WDT_COUNT_ADDR: rd_mux[`WDT_CNT_WIDTH-1:0] = count;
	default: rd_ok = 1'b0;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'b00;
	end else begin
		s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
			(!s_axi_rvalid && !s_axi_arready);
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

// *** test/wdt_top_sva.sv ***
// Purpose: Port checks on the watchdog top
// Assumes: One clock, synchronous low reset
// Notes: Bound into wdt_top
`timescale 1ns/10ps
module wdt_top_sva (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic wdt_reset_req
);
	logic [13:0] since_rst_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	always @(posedge aclk) begin
		if (!aresetn)
			since_rst_r <= 14'h0000;
		else if (!since_rst_r[13])
			since_rst_r <= since_rst_r + 14'h0001;
	end
	single_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("reset request too long");
	req_gap_a: assert property (wdt_reset_req |=> !wdt_reset_req [*8])
		else $error("reset requests too close");
	early_timeout_a: assert property (wdt_reset_req |-> since_rst_r[13])
		else $error("reset request too early");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while bvalid");
	b_latency_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	r_latency_a: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
endmodule
bind wdt_top wdt_top_sva i_wdt_top_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdt_reset_req(wdt_reset_req));

// *** test/wdt_cpu_model.sv ***
// Purpose: Software side bus master for the watchdog
// Assumes: AXI4-Lite, one transfer at a time
// Notes: Released payloads show inverted data
`timescale 1ns/10ps
module wdt_cpu_model (
	input logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Requests come only from the main sequence
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_wstrb = 4'hf;
	end
	task wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		begin
			ta = 1'b0;
			tw = 1'b0;
			s_axi_awaddr <= ad;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			while (!(ta && tw)) begin
				@(posedge aclk);
				if (!ta && s_axi_awready) begin
					ta = 1'b1;
					s_axi_awvalid <= 1'b0;
					s_axi_awaddr <= ~ad;
				end
				if (!tw && s_axi_wready) begin
					tw = 1'b1;
					s_axi_wvalid <= 1'b0;
					s_axi_wdata <= ~d;
				end
			end
			s_axi_bready <= 1'b1;
			do @(posedge aclk); while (!s_axi_bvalid);
			r = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
		begin
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1'b1;
			do @(posedge aclk); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			s_axi_araddr <= ~ad;
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (!s_axi_rvalid);
			d = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
endmodule

// *** test/wdt_top_tb.sv ***
// Purpose: Register level tests of the watchdog
// Assumes: 25 MHz aclk
// Notes: Bus short time-out keeps the run brief
`timescale 1ns/10ps
module wdt_top_tb;
	logic aclk = 1'b0, aresetn = 1'b0, stop_mode = 1'b0, debug_mode = 1'b0, por_event = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, a;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wdt_reset_req, irq;
	integer n_errors = 0, num_checks = 0, k;
	always #20 aclk = ~aclk;
	wdt_top i_wdt_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .debug_mode, .por_event,
		.wdt_reset_req, .irq);
	wdt_cpu_model i_wdt_cpu_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rdc(input logic [7:0] ad, input logic [31:0] exp);
		begin
			i_wdt_cpu_model.rd(ad, rd, resp);
			chk(rd, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		i_wdt_cpu_model.wr(ad, d, resp);
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge aclk);
	endtask
	task wait_req;
		for (k = 0; k < 9000 && wdt_reset_req !== 1'b1; k = k + 1) @(posedge aclk);
	endtask
	task summarize;
		begin
			if (n_errors == 0 && num_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		summarize;
	end
	initial begin
		cyc(5);
		aresetn <= 1'b1;
		por_event <= 1'b1;
		cyc(1);
		por_event <= 1'b0;
		cyc(1);
		i_wdt_cpu_model.rd(8'h18, rd, resp);
		chk({30'h0, resp}, 32'h2);
		wr(8'h18, 32'h1);
		chk({30'h0, resp}, 32'h2);
		rdc(8'h00, 32'h3);
		rdc(8'h04, 32'h0);
		rdc(8'h08, 32'h2);
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h0);
		rdc(8'h00, 32'h1);
		rdc(8'h0c, 32'h4);
		chk(irq, 32'h0);
		cyc(3000);
		i_wdt_cpu_model.rd(8'h14, rd, resp);
		chk(rd >= 32'd3000 && rd < 32'd3100, 32'h1);
		wr(8'h08, 32'hffffffff);
		chk({30'h0, resp}, 32'h0);
		i_wdt_cpu_model.rd(8'h14, rd, resp);
		chk(rd < 32'd20, 32'h1);
		rdc(8'h08, 32'h2);
		for (k = 0; k < 2; k = k + 1) begin
			if (k == 0)
				debug_mode <= 1'b1;
			else
				stop_mode <= 1'b1;
			cyc(2);
			i_wdt_cpu_model.rd(8'h14, a, resp);
			cyc(100);
			rdc(8'h14, a);
			debug_mode <= 1'b0;
			stop_mode <= 1'b0;
			cyc(50);
			i_wdt_cpu_model.rd(8'h14, rd, resp);
			chk(rd > a, 32'h1);
		end
		wr(8'h10, 32'h2);
		rdc(8'h10, 32'h2);
		wr(8'h08, 32'h0);
		wait_req;
		chk(k > 8100 && k < 8200, 32'h1);
		cyc(2);
		chk(irq, 32'h1);
		i_wdt_cpu_model.rd(8'h0c, rd, resp);
		chk(rd, 32'h3);
		cyc(2);
		chk(irq, 32'h0);
		i_wdt_cpu_model.rd(8'h08, rd, resp);
		chk(rd[0], 32'h1);
		aresetn <= 1'b0;
		cyc(5);
		aresetn <= 1'b1;
		cyc(1);
		rdc(8'h00, 32'h3);
		rdc(8'h04, 32'h0);
		rdc(8'h08, 32'h1);
		cyc(3000);
		i_wdt_cpu_model.rd(8'h14, rd, resp);
		chk(rd >= 32'd3 && rd <= 32'd4, 32'h1);
		stop_mode <= 1'b1;
		cyc(3);
		rdc(8'h14, 32'h0);
		stop_mode <= 1'b0;
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h0);
		rdc(8'h00, 32'h0);
		wait_req;
		chk(k, 32'd9000);
		rdc(8'h14, 32'h0);
		summarize;
	end
endmodule
